// ==== src/hpsc_top.v ====
// Four-slot hot-plug control sequencer with an AXI4-Lite register slave,
// a shared quiet-bus request/grant arbiter and an event interrupt.
// Assumes PCI pins arrive asynchronous and are synchronised here.
//
// Contract
// - Slot power output follows control bit 5.
// - With the interlock on, slot power may be high only while both detects are low.
// - In manual mode the bus switch output follows control bit 4 directly.
// - In automatic mode writing bit 4 as 1 requests a quiet bus, then waits for it.
// - Once quiet, disconnect sets bus and clock switch high, wide switch and power low.
// - In automatic mode writing bit 4 as 0 requests a quiet bus, then drives bus low.
// - An automatic connect with interlock on also waits for both detects asserted.
// - The slot wide indication output follows control bit 3.
// - The wide request switch output follows control bit 2.
// - The slot clock switch output follows control bit 1.
// - The slot reset output follows control bit 0.
// - Each bus switch change sets a sticky bus event flag cleared by writing 1.
// - There is one control register per slot, at indices 02h, 0Ah, 12h and 1Ah.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`include "hpsc_defs.vh"
module hpsc_top (
	input wire clock_in,
	input wire rst_n_in,
	input wire [7:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	output wire [1:0] s_axi_bresp_out,
	output wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0] s_axi_rresp_out,
	output wire s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire quiet_grant_in,
	input wire frame_n_in,
	input wire irdy_n_in,
	input wire [7:0] mech_detect_n_in,
	output wire quiet_request_out,
	output wire irq_out,
	output wire [3:0] slot_power_out,
	output wire [3:0] bus_switch_out,
	output wire [3:0] slot_clock_switch_out,
	output wire [3:0] wide_request_switch_out,
	output wire [3:0] slot_wide_indication_out,
	output wire [3:0] slot_reset_out
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	reg [10:0] pin_s1_r;
	reg [10:0] pin_s2_r;
	wire grant_s;
	wire frame_idle_s;
	wire irdy_idle_s;
	wire [7:0] detect_s;

	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			pin_s1_r <= `HPSC_SYNC_RESET;
			pin_s2_r <= `HPSC_SYNC_RESET;
		end else begin
			pin_s1_r <= {quiet_grant_in, frame_n_in, irdy_n_in, mech_detect_n_in};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign grant_s = pin_s2_r[10];
	assign frame_idle_s = pin_s2_r[9];
	assign irdy_idle_s = pin_s2_r[8];
	assign detect_s = pin_s2_r[7:0];

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	reg awready_r;
	reg wready_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg aw_held_r;
	reg w_held_r;
	reg [5:0] waddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	wire aw_take;
	wire w_take;
	wire wr_fire;
	wire aw_held_nxt;
	wire w_held_nxt;
	wire bvalid_nxt;
	wire [31:0] wmask;
	wire wr_ctrl_hit;
	wire wr_hit;

	assign aw_take = s_axi_awvalid_in & awready_r;
	assign w_take = s_axi_wvalid_in & wready_r;
	assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
	assign aw_held_nxt = (aw_held_r & ~wr_fire) | aw_take;
	assign w_held_nxt = (w_held_r & ~wr_fire) | w_take;
	assign bvalid_nxt = wr_fire | (bvalid_r & ~s_axi_bready_in);
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `HPSC_RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= 6'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			bvalid_r <= bvalid_nxt;
			awready_r <= ~aw_held_nxt & ~bvalid_nxt;
			wready_r <= ~w_held_nxt & ~bvalid_nxt;
			if (aw_take) begin
				waddr_r <= s_axi_awaddr_in[7:2];
			end
			if (w_take) begin
				wdata_r <= s_axi_wdata_in;
				wstrb_r <= s_axi_wstrb_in;
			end
			if (wr_fire) begin
				bresp_r <= wr_hit ? `HPSC_RESP_OKAY : `HPSC_RESP_SLVERR;
			end
		end
	end

	assign s_axi_awready_out = awready_r;
	assign s_axi_wready_out = wready_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;

	////////////////////////////////////////////////////////////////////
	// Configuration, event status, clear and enable registers
	reg [1:0] cfg_r;
	reg [31:0] stat_r;
	reg [31:0] en_r;
	reg irq_r;
	wire [3:0] bus_ev;
	wire [31:0] ev_word;
	wire [31:0] clr_word;
	wire [31:0] stat_nxt;
	wire wr_cfg;
	wire wr_clr;
	wire wr_en;

	assign wr_cfg = wr_fire & (waddr_r == `HPSC_IDX_CONFIG) & wstrb_r[0];
	assign wr_clr = wr_fire & (waddr_r == `HPSC_IDX_CLEAR);
	assign wr_en = wr_fire & (waddr_r == `HPSC_IDX_ENABLE);
	assign wr_hit = wr_ctrl_hit | (waddr_r == `HPSC_IDX_CONFIG) |
		(waddr_r == `HPSC_IDX_STATUS) | (waddr_r == `HPSC_IDX_CLEAR) |
		(waddr_r == `HPSC_IDX_ENABLE);
	assign ev_word = {1'b0, bus_ev[3], 6'h00, 1'b0, bus_ev[2], 6'h00,
		1'b0, bus_ev[1], 6'h00, 1'b0, bus_ev[0], 6'h00};
	assign clr_word = wr_clr ? (wdata_r & wmask) : 32'h00000000;
	// A new event beats a clear in the same cycle
	assign stat_nxt = ((stat_r & ~clr_word) | ev_word) & `HPSC_EVT_MASK;

	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			cfg_r <= `HPSC_CFG_RESET;
			stat_r <= `HPSC_STAT_RESET;
			en_r <= `HPSC_STAT_RESET;
			irq_r <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg_r <= wdata_r[1:0];
			end
			if (wr_en) begin
				en_r <= ((en_r & ~wmask) | (wdata_r & wmask)) & `HPSC_EVT_MASK;
			end
			stat_r <= stat_nxt;
			irq_r <= |(stat_nxt & en_r);
		end
	end

	assign irq_out = irq_r;

	////////////////////////////////////////////////////////////////////
	// Quiet-bus arbiter: one slot sequences at a time, lowest index first
	reg [3:0] owner_r;
	reg quiet_req_r;
	reg [3:0] owner_nxt;
	wire [3:0] seq_req;
	wire bus_quiet;

	// FRAME# and IRDY# both deasserted and quiet granted
	assign bus_quiet = quiet_req_r & grant_s & frame_idle_s & irdy_idle_s;

	always @* begin
		owner_nxt = owner_r;
		// A new owner waits until the last grant has been withdrawn
		if ((owner_r == 4'h0) && !grant_s) begin
			if (seq_req[0]) begin
				owner_nxt = 4'h1;
			end else if (seq_req[1]) begin
				owner_nxt = 4'h2;
			end else if (seq_req[2]) begin
				owner_nxt = 4'h4;
			end else if (seq_req[3]) begin
				owner_nxt = 4'h8;
			end
		end else if ((owner_r & seq_req) == 4'h0) begin
			owner_nxt = 4'h0;
		end
	end

	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			owner_r <= 4'h0;
			quiet_req_r <= 1'b0;
		end else begin
			owner_r <= owner_nxt;
			quiet_req_r <= (owner_nxt != 4'h0);
		end
	end

	assign quiet_request_out = quiet_req_r;

	////////////////////////////////////////////////////////////////////
	// Slots
	wire [7:0] ctrl_rd [0:3];
	wire [3:0] wr_slot;
	wire [3:0] rd_slot;

	genvar s;
	generate
		for (s = 0; s < 4; s = s + 1) begin : g_slot
			localparam [31:0] CIDX_W = `HPSC_IDX_CTRL0 + `HPSC_IDX_SLOT_STEP * s;
			localparam [5:0] CIDX = CIDX_W[5:0];
			assign wr_slot[s] = (waddr_r == CIDX);
			assign rd_slot[s] = (s_axi_araddr_in[7:2] == CIDX);
			hpsc_slot u_slot (
				.clock_in(clock_in),
				.rst_n_in(rst_n_in),
				.wr_in(wr_fire & wr_slot[s] & wstrb_r[0]),
				.wdata_in(wdata_r[7:0]),
				.auto_mode_in(cfg_r[`HPSC_CFG_AUTO]),
				.interlock_enable_in(cfg_r[`HPSC_CFG_INTERLOCK]),
				.detect_n_in(detect_s[2*s+1:2*s]),
				.go_in(bus_quiet & owner_r[s]),
				.ctrl_out(ctrl_rd[s]),
				.seq_req_out(seq_req[s]),
				.bus_event_out(bus_ev[s]),
				.slot_power_out(slot_power_out[s]),
				.bus_switch_out(bus_switch_out[s]),
				.slot_clock_switch_out(slot_clock_switch_out[s]),
				.wide_request_switch_out(wide_request_switch_out[s]),
				.slot_wide_indication_out(slot_wide_indication_out[s]),
				.slot_reset_out(slot_reset_out[s])
			);
		end
	endgenerate

	assign wr_ctrl_hit = |wr_slot;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	reg arready_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	reg [31:0] rd_word;
	reg rd_hit;
	wire ar_take;
	wire rvalid_nxt;
	wire [5:0] ridx;

	assign ar_take = s_axi_arvalid_in & arready_r;
	assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_in);
	assign ridx = s_axi_araddr_in[7:2];

	always @* begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		if (rd_slot[0]) begin
			rd_word = {24'h000000, ctrl_rd[0]};
		end else if (rd_slot[1]) begin
			rd_word = {24'h000000, ctrl_rd[1]};
		end else if (rd_slot[2]) begin
			rd_word = {24'h000000, ctrl_rd[2]};
		end else if (rd_slot[3]) begin
			rd_word = {24'h000000, ctrl_rd[3]};
		end else if (ridx == `HPSC_IDX_CONFIG) begin
			rd_word = {24'h000000, seq_req, 2'b00, cfg_r};
		end else if (ridx == `HPSC_IDX_STATUS) begin
			rd_word = stat_r;
		end else if (ridx == `HPSC_IDX_ENABLE) begin
			rd_word = en_r;
		end else if (ridx == `HPSC_IDX_CLEAR) begin
			rd_word = 32'h00000000;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `HPSC_RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			arready_r <= ~rvalid_nxt;
			if (ar_take) begin
				rdata_r <= rd_word;
				rresp_r <= rd_hit ? `HPSC_RESP_OKAY : `HPSC_RESP_SLVERR;
			end
		end
	end

	assign s_axi_arready_out = arready_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rdata_out = rdata_r;
	assign s_axi_rresp_out = rresp_r;
endmodule // hpsc_top

// ==== src/hpsc_defs.vh ====
// Constants of the hot-plug slot control sequencer.
// Included by every design file; holds definitions only.
`ifndef HPSC_DEFS_VH
`define HPSC_DEFS_VH

// Register indices, byte address is four times the index
`define HPSC_IDX_CTRL0 6'h02
`define HPSC_IDX_SLOT_STEP 6'h08
`define HPSC_IDX_CONFIG 6'h20
`define HPSC_IDX_STATUS 6'h21
`define HPSC_IDX_CLEAR 6'h22
`define HPSC_IDX_ENABLE 6'h23

// Slot connection control fields
`define HPSC_BIT_POWER 5
`define HPSC_BIT_BUS 4
`define HPSC_BIT_WIDE_IND 3
`define HPSC_BIT_WIDE_SW 2
`define HPSC_BIT_CLK 1
`define HPSC_BIT_RST 0
`define HPSC_CTRL_RESET 6'h2d

// General configuration fields
`define HPSC_CFG_AUTO 0
`define HPSC_CFG_INTERLOCK 1
`define HPSC_CFG_BUSY_LSB 4
`define HPSC_CFG_RESET 2'h0

// Event status layout: one byte per slot
`define HPSC_EVT_BIT 6
`define HPSC_EVT_MASK 32'h40404040
`define HPSC_STAT_RESET 32'h00000000

// Pin synchroniser reset: grant idles low, bus and detects idle high
`define HPSC_SYNC_RESET 11'h3ff

// Bus responses
`define HPSC_RESP_OKAY 2'h0
`define HPSC_RESP_SLVERR 2'h2

`endif

// ==== src/hpsc_slot.v ====
// One slot: connection control register, output pins and the
// automatic connect/disconnect sequencer.
// Assumes synchronised detect inputs and a go level from the shared arbiter.
`include "hpsc_defs.vh"
module hpsc_slot (
	input wire clock_in,
	input wire rst_n_in,
	input wire wr_in,
	input wire [7:0] wdata_in,
	input wire auto_mode_in,
	input wire interlock_enable_in,
	input wire [1:0] detect_n_in,
	input wire go_in,
	output wire [7:0] ctrl_out,
	output wire seq_req_out,
	output wire bus_event_out,
	output wire slot_power_out,
	output wire bus_switch_out,
	output wire slot_clock_switch_out,
	output wire wide_request_switch_out,
	output wire slot_wide_indication_out,
	output wire slot_reset_out
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_DROP = 3'b100;
	localparam [5:0] CTRL_RST = `HPSC_CTRL_RESET;

	reg [2:0] state_r, state_nxt;
	reg [5:0] ctrl_r, ctrl_nxt;
	reg bus_sw_r, bus_sw_nxt;
	reg pend_r, pend_nxt;
	reg power_r, req_r, ev_r;
	wire det_ok;
	wire disc;

	// Both detects asserted (low), or interlock off
	assign det_ok = ~interlock_enable_in | (detect_n_in == 2'b00);
	assign disc = ctrl_r[`HPSC_BIT_BUS];

	////////////////////////////////////////////////////////////////////
	always @* begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		bus_sw_nxt = bus_sw_r;
		pend_nxt = pend_r;
		case (state_r)
			ST_IDLE: begin
				if (pend_r) begin
					state_nxt = ST_WAIT;
					pend_nxt = 1'b0;
				end
			end
			ST_WAIT: begin
				if (!auto_mode_in) begin
					state_nxt = ST_DROP;
				end else if (go_in && (disc || det_ok)) begin
					state_nxt = ST_DROP;
					bus_sw_nxt = disc;
					if (disc) begin
						ctrl_nxt[`HPSC_BIT_CLK] = 1'b1;
						ctrl_nxt[`HPSC_BIT_WIDE_SW] = 1'b0;
						ctrl_nxt[`HPSC_BIT_POWER] = 1'b0;
					end
				end
			end
			ST_DROP: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (wr_in) begin
			ctrl_nxt = wdata_in[5:0];
			if (auto_mode_in) begin
				pend_nxt = 1'b1;
			end
		end
		if (!auto_mode_in) begin
			pend_nxt = 1'b0;
			bus_sw_nxt = ctrl_nxt[`HPSC_BIT_BUS];
		end
	end

	////////////////////////////////////////////////////////////////////
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_r <= ST_IDLE;
			ctrl_r <= CTRL_RST;
			bus_sw_r <= CTRL_RST[`HPSC_BIT_BUS];
			pend_r <= 1'b0;
			power_r <= CTRL_RST[`HPSC_BIT_POWER];
			req_r <= 1'b0;
			ev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			bus_sw_r <= bus_sw_nxt;
			pend_r <= pend_nxt;
			power_r <= ctrl_nxt[`HPSC_BIT_POWER] & det_ok;
			req_r <= (state_nxt == ST_WAIT);
			ev_r <= bus_sw_nxt ^ bus_sw_r;
		end
	end

	assign ctrl_out = {2'b00, ctrl_r};
	assign seq_req_out = req_r;
	assign bus_event_out = ev_r;
	assign slot_power_out = power_r;
	assign bus_switch_out = bus_sw_r;
	assign slot_clock_switch_out = ctrl_r[`HPSC_BIT_CLK];
	assign wide_request_switch_out = ctrl_r[`HPSC_BIT_WIDE_SW];
	assign slot_wide_indication_out = ctrl_r[`HPSC_BIT_WIDE_IND];
	assign slot_reset_out = ctrl_r[`HPSC_BIT_RST];
endmodule // hpsc_slot

// ==== tb/hpsc_top_properties.sv ====
// Port checker for the four-slot sequencer top.
// Bound to hpsc_top from the testbench top file.
module hpsc_top_properties (
	input wire clock_in,
	input wire rst_n_in,
	input wire s_axi_awready_out,
	input wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire s_axi_arready_out,
	input wire s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire [31:0] s_axi_rdata_out,
	input wire quiet_request_out,
	input wire quiet_grant_in,
	input wire frame_n_in,
	input wire irdy_n_in,
	input wire irq_out,
	input wire [3:0] slot_power_out,
	input wire [3:0] bus_switch_out,
	input wire [3:0] slot_clock_switch_out,
	input wire [3:0] wide_request_switch_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	chk_reset_idle: assert property (!$past(rst_n_in) |-> !s_axi_bvalid_out && !irq_out
		&& !quiet_request_out && !s_axi_awready_out) else $error("not idle after reset");
	chk_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped early");
	chk_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
		&& $stable(s_axi_rdata_out)) else $error("read data not held");
	chk_no_read_overlap: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read address taken during response");
	chk_no_write_overlap: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
		else $error("write address taken during response");
	chk_switch_after_grant: assert property ($changed(bus_switch_out) && quiet_request_out
		|-> $past(quiet_grant_in, 3)) else $error("bus switch moved before grant");
	chk_switch_bus_idle: assert property ($changed(bus_switch_out) && quiet_request_out
		|-> $past(frame_n_in, 3) && $past(irdy_n_in, 3))
		else $error("bus switch moved on busy bus");
	chk_disconnect_pins: assert property ($rose(bus_switch_out[0]) && quiet_request_out
		|-> ##1 !slot_power_out[0] && slot_clock_switch_out[0] && !wide_request_switch_out[0])
		else $error("disconnect pins wrong");
	chk_request_held: assert property ($rose(quiet_request_out) |=> quiet_request_out [*2])
		else $error("quiet request too short");
endmodule // hpsc_top_properties

// ==== tb/hpsc_bus_model.sv ====
// Model of the system bus arbiter and PCI bus traffic.
// Bus toggles while no quiet request; grants dly_in+1 cycles after the request.
module hpsc_bus_model (
	input wire clock_in,
	input wire rst_n_in,
	input wire quiet_request_in,
	input wire [3:0] dly_in,
	output logic quiet_grant_out = 1'b0,
	output logic frame_n_out = 1'b1,
	output logic irdy_n_out = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r = 4'h0;
	always @(posedge clock_in) begin
		if (!rst_n_in || !quiet_request_in) begin
			wait_r <= 4'h0;
			quiet_grant_out <= 1'b0;
			frame_n_out <= ~frame_n_out;
			irdy_n_out <= frame_n_out;
		end else begin
			frame_n_out <= 1'b1;
			irdy_n_out <= 1'b1;
			if (wait_r != dly_in)
				wait_r <= wait_r + 4'h1;
			else
				quiet_grant_out <= 1'b1;
		end
	end
endmodule // hpsc_bus_model

// ==== tb/tb.sv ====
// Testbench top: AXI4-Lite tasks and slot control scenarios.
// Assumes hpsc_bus_model on the quiet-bus pins; detects driven here.
bind hpsc_top hpsc_top_properties chk_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.s_axi_rdata_out(s_axi_rdata_out), .quiet_request_out(quiet_request_out),
	.quiet_grant_in(quiet_grant_in), .frame_n_in(frame_n_in), .irdy_n_in(irdy_n_in),
	.irq_out(irq_out), .slot_power_out(slot_power_out),
	.bus_switch_out(bus_switch_out), .slot_clock_switch_out(slot_clock_switch_out),
	.wide_request_switch_out(wide_request_switch_out));
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 0, rst_n_in = 0;
	logic [7:0] awaddr = 0, araddr = 0, detect_n = 8'hff;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] dly = 4'h7, wstrb = 4'hf;
	logic [5:0] e;
	wire awready, wready, bvalid, arready, rvalid, grant, frame_n, irdy_n, quiet, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] pwr, bsw, csw, wsw, wind, srst;
	int failures = 0, cmp_count = 0;
	hpsc_top dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .quiet_grant_in(grant), .frame_n_in(frame_n),
		.irdy_n_in(irdy_n), .mech_detect_n_in(detect_n), .quiet_request_out(quiet),
		.irq_out(irq), .slot_power_out(pwr), .bus_switch_out(bsw),
		.slot_clock_switch_out(csw), .wide_request_switch_out(wsw),
		.slot_wide_indication_out(wind), .slot_reset_out(srst));
	hpsc_bus_model bus_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .quiet_request_in(quiet),
		.dly_in(dly), .quiet_grant_out(grant), .frame_n_out(frame_n), .irdy_n_out(irdy_n));
	initial begin
		forever #4 clock_in = ~clock_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] pins(input int s);
		return {26'h0, pwr[s], bsw[s], wind[s], wsw[s], csw[s], srst[s]};
	endfunction
	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
		@(negedge clock_in);
	endtask
	task automatic wait_bus(input int s, input logic v);
		do @(negedge clock_in); while (bsw[s] !== v);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge clock_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_ok && w_ok)) begin
			@(negedge clock_in);
			aw_ok = aw_ok || awready === 1'b1;
			w_ok = w_ok || wready === 1'b1;
			@(posedge clock_in);
			if (aw_ok)
				awvalid <= 0;
			if (w_ok)
				wvalid <= 0;
		end
		while (bvalid !== 1'b1)
			@(negedge clock_in);
		chk({30'h0, bresp}, {30'h0, er});
		@(posedge clock_in);
		bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(negedge clock_in); while (arready !== 1'b1);
		@(posedge clock_in);
		arvalid <= 0;
		do @(negedge clock_in); while (rvalid !== 1'b1);
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
		@(posedge clock_in);
		rready <= 0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clock_in);
		failures++;
		$display("FAIL %0t watchdog expired", $time);
		finish_test;
	end
	initial begin
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1;
		settle(1);
		for (int s = 0; s < 4; s++)
			chk(pins(s), 32'h2d);
		axi_rd(8'h08, 32'h2d, 2'h0);
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 2; k++) begin
				e = k ? 6'h00 : 6'h3f;
				axi_wr(8'(8 + 32 * s), {24'h0, 2'b11, e}, 2'h0);
				axi_rd(8'(8 + 32 * s), {26'h0, e}, 2'h0);
				chk(pins(s), {26'h0, e});
			end
		end
		$display("test manual done");
		axi_rd(8'h84, 32'h40404040, 2'h0);
		axi_wr(8'h88, 32'h40404040, 2'h0);
		axi_rd(8'h84, 32'h0, 2'h0);
		axi_wr(8'h8c, 32'h0, 2'h0);
		axi_wr(8'h08, 32'h10, 2'h0);
		settle(4);
		chk({31'h0, irq}, 32'h0);
		axi_wr(8'h8c, 32'h40, 2'h0);
		axi_rd(8'h8c, 32'h40, 2'h0);
		settle(4);
		chk({31'h0, irq}, 32'h1);
		axi_wr(8'h88, 32'h40, 2'h0);
		settle(4);
		chk({31'h0, irq}, 32'h0);
		axi_rd(8'h88, 32'h0, 2'h0);
		axi_wr(8'hfc, 32'h0, 2'h2);
		axi_rd(8'hfc, 32'h0, 2'h2);
		@(posedge clock_in);
		wstrb <= 4'he;
		axi_wr(8'h68, 32'h3f, 2'h0);
		wstrb <= 4'hf;
		axi_rd(8'h68, 32'h0, 2'h0);
		$display("test event done");
		axi_wr(8'h80, 32'h2, 2'h0);
		axi_wr(8'h08, 32'h30, 2'h0);
		settle(4);
		chk(pins(0), 32'h10);
		@(posedge clock_in);
		detect_n <= 8'hfc;
		settle(6);
		chk(pins(0), 32'h30);
		$display("test interlock done");
		axi_wr(8'h08, 32'h24, 2'h0);
		axi_wr(8'h80, 32'h3, 2'h0);
		axi_wr(8'h08, 32'h34, 2'h0);
		settle(1);
		chk({31'h0, quiet}, 32'h1);
		chk({31'h0, bsw[0]}, 32'h0);
		wait_bus(0, 1);
		settle(2);
		chk(pins(0), 32'h12);
		axi_rd(8'h08, 32'h12, 2'h0);
		axi_wr(8'h08, 32'h02, 2'h0);
		wait_bus(0, 0);
		$display("test auto slot0 done");
		@(posedge clock_in);
		dly <= 4'h1;
		axi_wr(8'h28, 32'h10, 2'h0);
		wait_bus(1, 1);
		axi_wr(8'h28, 32'h00, 2'h0);
		settle(30);
		chk({30'h0, quiet, bsw[1]}, 32'h3);
		axi_rd(8'h80, 32'h23, 2'h0);
		@(posedge clock_in);
		detect_n <= 8'hf0;
		wait_bus(1, 0);
		settle(4);
		chk({31'h0, quiet}, 32'h0);
		axi_rd(8'h84, 32'h4040, 2'h0);
		$display("test auto slot1 done");
		finish_test;
	end
endmodule // tb
